// ==== wdit_defines.svh ====
// Notes on behaviour
// - mode bit 0: interval timer, overflow interrupts
// - channel 0 mode 1: watchdog, selectable reset
// - channel 1 mode 1: watchdog, reset or nmi
// - channel 1 select bit picks reset or nmi
// - channel 1 select 0 gives nmi request
// - interval interrupt on every overflow, periodic
// - interval mode never raises nmi
// - watchdog reset overflow resets whole chip
// - watchdog overflow never raises interval interrupt
// - count sub-clock while sub-clock operates
`ifndef WDIT_DEFINES_SVH
`define WDIT_DEFINES_SVH

// register byte offsets
`define WDIT_OFS_CTRL0 4'h0
`define WDIT_OFS_COUNT0 4'h1
`define WDIT_OFS_CTRL1 4'h2
`define WDIT_OFS_COUNT1 4'h3
`define WDIT_OFS_STATUS 4'h4

// control/status field positions
`define WDIT_BIT_OVF 7
`define WDIT_BIT_MODE 6
`define WDIT_BIT_RUN 5
`define WDIT_BIT_SEL 4
`define WDIT_BIT_KIND 3
`define WDIT_CKS_HI 2
`define WDIT_CKS_LO 0

// status field positions
`define WDIT_BIT_WOVF0 0
`define WDIT_BIT_WOVF1 1

// reset values
`define WDIT_CTRL_RST 8'h00
`define WDIT_COUNT_RST 8'h00

// internal reset pulse: time in ns and derived cycles at 10 ns
`define WDIT_RST_TIME_NS 160
`define WDIT_CLK_NS 10
`define WDIT_RST_CYCLES ((`WDIT_RST_TIME_NS + `WDIT_CLK_NS - 1) / `WDIT_CLK_NS)

`endif

// ==== wdit_pkg.sv ====
package wdit_pkg;

  // one channel control/status register
  typedef struct packed {
    logic ovf;       // counter_overflow_flag
    logic mode;      // timer_mode_select
    logic run;       // count enable
    logic sel;       // ch0 reset enable, ch1 reset/nmi select
    logic kind;      // ch0 reset kind, 1 = manual
    logic [2:0] cks; // prescaler tap select
  } wdit_ctrl_t;

  // internal reset request carrier
  typedef struct packed {
    logic req;
    logic manual;
  } wdit_rst_t;

  typedef enum logic [1:0] {
    WDIT_IDLE = 2'b00,
    WDIT_HOLD = 2'b01,
    WDIT_LAST = 2'b11
  } wdit_state_t;

endpackage : wdit_pkg

// ==== wdit_counter.sv ====
`timescale 1ns/1ns
module wdit_counter #(
  parameter int W = 8
) (
  input wire logic clk,            // system clock
  input wire logic arst_n,         // async reset, active low
  input wire logic run,            // counting allowed
  input wire logic tick,           // one-cycle count enable
  input wire logic load,           // software write to counter
  input wire logic [W-1:0] load_val, // value to load
  output logic [W-1:0] count,      // current count
  output logic ovf                 // one-cycle overflow pulse
);

  logic [W-1:0] count_d;
  logic [W-1:0] count_q;
  logic ovf_d;
  logic ovf_q;

  // a load wins over a tick so software always sees its own value
  always_comb begin
    count_d = count_q;
    ovf_d = 1'b0;
    if (load) begin
      count_d = load_val;
    end else if (run && tick) begin
      count_d = count_q + {{(W-1){1'b0}}, 1'b1};
      ovf_d = &count_q;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_q <= '0;
      ovf_q <= 1'b0;
    end else begin
      count_q <= count_d;
      ovf_q <= ovf_d;
    end
  end

  assign count = count_q;
  assign ovf = ovf_q;

endmodule : wdit_counter

// ==== wdit_timer.sv ====
`timescale 1ns/1ns
`include "wdit_defines.svh"
module wdit_timer #(
  parameter int CNT_W = 8,
  parameter int PRE_W = 16,
  parameter int RST_CYCLES = `WDIT_RST_CYCLES
) (
  input wire logic clk,               // system clock, 100 MHz
  input wire logic arst_n,            // async reset, active low
  input wire logic [3:0] addr,        // register byte address
  input wire logic [7:0] wdata,       // write data
  input wire logic wr_en,             // write strobe
  input wire logic rd_en,             // read strobe
  output logic [7:0] rdata,           // read data, cycle after strobe
  input wire logic sub_clk_active,    // sub-clock is the operating clock
  input wire logic sub_clk_tick,      // one pulse per sub-clock period
  output logic [1:0] interval_overflow_irq, // interval interrupt per channel
  output logic nmi_req,               // one-cycle nmi request
  output logic chip_reset,            // internal reset to whole chip
  output logic chip_reset_manual      // kind of that reset, 1 = manual
);

  localparam int NCH = 2;
  localparam logic [15:0] RST_LEN = RST_CYCLES[15:0];

  // register state
  wdit_pkg::wdit_ctrl_t ctrl_d [NCH];
  wdit_pkg::wdit_ctrl_t ctrl_q [NCH];
  logic [NCH-1:0] watchdog_overflow_flag_d;
  logic [NCH-1:0] watchdog_overflow_flag_q;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;

  // prescaler state
  logic [PRE_W-1:0] pre_d;
  logic [PRE_W-1:0] pre_q;
  logic base_tick;

  // channel wiring
  logic [NCH-1:0] ch_tick;
  logic [NCH-1:0] ch_load;
  logic [NCH-1:0] ch_ovf;
  logic [CNT_W-1:0] ch_count [NCH];
  logic [NCH-1:0] wr_ctrl;
  logic [NCH-1:0] rd_ctrl;
  logic [NCH-1:0] iv_evt;
  logic [NCH-1:0] wd_evt;

  // event outputs
  logic [NCH-1:0] irq_d;
  logic [NCH-1:0] irq_q;
  logic nmi_d;
  logic nmi_q;

  // reset sequencer
  wdit_pkg::wdit_state_t st_d;
  wdit_pkg::wdit_state_t st_q;
  logic [15:0] hold_d;
  logic [15:0] hold_q;
  wdit_pkg::wdit_rst_t rst_req;
  logic rst_out_d;
  logic rst_out_q;
  logic kind_d;
  logic kind_q;

  // base count rate follows the operating clock
  always_comb begin
    base_tick = sub_clk_active ? sub_clk_tick : 1'b1;
  end

  // free prescaler advances only on base ticks, so sub-clock taps stay exact
  always_comb begin
    pre_d = pre_q;
    if (base_tick) begin
      pre_d = pre_q + {{(PRE_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_d;
    end
  end

  // tap n ticks when the low 2n+1 prescaler bits are all ones
  function automatic logic tap_hit(input logic [PRE_W-1:0] pre, input logic [2:0] cks);
    logic [PRE_W-1:0] mask;
    logic [4:0] width;
    mask = '0;
    width = {1'b0, cks, 1'b0} + 5'h01;
    for (int b = 0; b < PRE_W; b++) begin
      if (b < int'(width)) begin
        mask[b] = 1'b1;
      end
    end
    tap_hit = ((pre & mask) == mask);
  endfunction : tap_hit

  // per channel: decode, counter and event split
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    always_comb begin
      wr_ctrl[c] = wr_en && (addr == (`WDIT_OFS_CTRL0 + 4'(2 * c)));
      rd_ctrl[c] = rd_en && (addr == (`WDIT_OFS_CTRL0 + 4'(2 * c)));
      ch_load[c] = wr_en && (addr == (`WDIT_OFS_COUNT0 + 4'(2 * c)));
      ch_tick[c] = base_tick && tap_hit(pre_q, ctrl_q[c].cks);
      iv_evt[c] = ch_ovf[c] && !ctrl_q[c].mode;
      wd_evt[c] = ch_ovf[c] && ctrl_q[c].mode;
    end

    wdit_counter #(
      .W(CNT_W)
    ) u_cnt (
      .clk(clk),
      .arst_n(arst_n),
      .run(ctrl_q[c].run),
      .tick(ch_tick[c]),
      .load(ch_load[c]),
      .load_val(wdata[CNT_W-1:0]),
      .count(ch_count[c]),
      .ovf(ch_ovf[c])
    );

    // control register: flag writes only clear, hardware set wins
    always_comb begin
      ctrl_d[c] = ctrl_q[c];
      if (wr_ctrl[c]) begin
        ctrl_d[c].mode = wdata[`WDIT_BIT_MODE];
        ctrl_d[c].run = wdata[`WDIT_BIT_RUN];
        ctrl_d[c].sel = wdata[`WDIT_BIT_SEL];
        ctrl_d[c].kind = (c == 0) ? wdata[`WDIT_BIT_KIND] : 1'b0;
        ctrl_d[c].cks = wdata[`WDIT_CKS_HI:`WDIT_CKS_LO];
        if (!wdata[`WDIT_BIT_OVF]) begin
          ctrl_d[c].ovf = 1'b0;
        end
      end
      if (iv_evt[c]) begin
        ctrl_d[c].ovf = 1'b1;
      end
    end

    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        ctrl_q[c] <= `WDIT_CTRL_RST;
      end else begin
        ctrl_q[c] <= ctrl_d[c];
      end
    end

    // watchdog flag lives apart from the interval flag
    always_comb begin
      watchdog_overflow_flag_d[c] = watchdog_overflow_flag_q[c];
      if (wr_en && (addr == `WDIT_OFS_STATUS) && !wdata[c]) begin
        watchdog_overflow_flag_d[c] = 1'b0;
      end
      if (wd_evt[c]) begin
        watchdog_overflow_flag_d[c] = 1'b1;
      end
    end

    // interval interrupt follows the flag, never a watchdog overflow
    always_comb begin
      irq_d[c] = ctrl_d[c].ovf && !ctrl_d[c].mode;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      watchdog_overflow_flag_q <= '0;
      irq_q <= '0;
    end else begin
      watchdog_overflow_flag_q <= watchdog_overflow_flag_d;
      irq_q <= irq_d;
    end
  end

  // watchdog consequences; only channel 1 may ask for nmi
  always_comb begin
    nmi_d = wd_evt[1] && !ctrl_q[1].sel;
    rst_req.req = 1'b0;
    rst_req.manual = 1'b0;
    if (wd_evt[1] && ctrl_q[1].sel) begin
      rst_req.req = 1'b1;
      rst_req.manual = 1'b0;
    end
    if (wd_evt[0] && ctrl_q[0].sel) begin
      rst_req.req = 1'b1;
      rst_req.manual = ctrl_q[0].kind;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      nmi_q <= 1'b0;
    end else begin
      nmi_q <= nmi_d;
    end
  end

  // reset pulse sequencer; a new request during the pulse is absorbed
  // because the chip is being reset anyway
  always_comb begin
    st_d = st_q;
    hold_d = hold_q;
    rst_out_d = rst_out_q;
    kind_d = kind_q;
    unique case (st_q)
      wdit_pkg::WDIT_IDLE: begin
        if (rst_req.req) begin
          st_d = (RST_LEN > 16'h0001) ? wdit_pkg::WDIT_HOLD : wdit_pkg::WDIT_LAST;
          hold_d = RST_LEN - 16'h0001;
          rst_out_d = 1'b1;
          kind_d = rst_req.manual;
        end
      end
      wdit_pkg::WDIT_HOLD: begin
        hold_d = hold_q - 16'h0001;
        // hold counts RST_LEN-1 cycles down to 1, then LAST adds the final cycle
        if (hold_q <= 16'h0001) begin
          st_d = wdit_pkg::WDIT_LAST;
        end
      end
      wdit_pkg::WDIT_LAST: begin
        st_d = wdit_pkg::WDIT_IDLE;
        hold_d = 16'h0000;
        rst_out_d = 1'b0;
      end
      default: begin
        st_d = wdit_pkg::WDIT_IDLE;
        rst_out_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= wdit_pkg::WDIT_IDLE;
      hold_q <= 16'h0000;
      rst_out_q <= 1'b0;
      kind_q <= 1'b0;
    end else begin
      st_q <= st_d;
      hold_q <= hold_d;
      rst_out_q <= rst_out_d;
      kind_q <= kind_d;
    end
  end

  // read mux; unmapped addresses read as zero
  always_comb begin
    rdata_d = 8'h00;
    if (rd_en) begin
      unique case (addr)
        `WDIT_OFS_CTRL0: rdata_d = ctrl_q[0];
        `WDIT_OFS_COUNT0: rdata_d = 8'(ch_count[0]);
        `WDIT_OFS_CTRL1: rdata_d = ctrl_q[1];
        `WDIT_OFS_COUNT1: rdata_d = 8'(ch_count[1]);
        `WDIT_OFS_STATUS: rdata_d = {6'h00, watchdog_overflow_flag_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // every output straight from a flop
  assign rdata = rdata_q;
  assign interval_overflow_irq = irq_q;
  assign nmi_req = nmi_q;
  assign chip_reset = rst_out_q;
  assign chip_reset_manual = kind_q;

endmodule : wdit_timer

// ==== wdit_timer_sva.sv ====
`timescale 1ns/1ns
module wdit_timer_sva #(
  parameter int RST_CYCLES = 16
) (
  input wire logic clk, // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic rd_en, // read strobe
  input wire logic [7:0] rdata, // read data
  input wire logic [1:0] interval_overflow_irq, // interval interrupts
  input wire logic nmi_req, // nmi pulse
  input wire logic chip_reset, // chip reset
  input wire logic chip_reset_manual // reset kind
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic [7:0] hi_d;
  logic [7:0] hi_q;
  // cycles the chip reset has stood so far, so its length needs no long repetition
  always_comb begin
    hi_d = chip_reset ? hi_q + 8'h01 : 8'h00;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hi_q <= 8'h00;
    end else begin
      hi_q <= hi_d;
    end
  end
  // outputs against their causes
  a_nmi_pulse: assert property (nmi_req |=> !nmi_req)
    else $error("nmi request longer than one cycle");
  a_nmi_no_irq: assert property (nmi_req |-> !interval_overflow_irq[1])
    else $error("interval interrupt beside nmi");
  a_irq_no_nmi: assert property ($rose(interval_overflow_irq[1]) |-> !nmi_req)
    else $error("nmi beside interval overflow");
  a_rst_short: assert property (chip_reset |-> hi_q < RST_CYCLES)
    else $error("chip reset too long");
  a_rst_length: assert property ($fell(chip_reset) |-> hi_q == RST_CYCLES)
    else $error("chip reset too short");
  a_manual_hold: assert property (chip_reset ##1 chip_reset |-> $stable(chip_reset_manual))
    else $error("reset kind changed while held");
  a_manual_no_irq: assert property (chip_reset && chip_reset_manual |-> !interval_overflow_irq[0])
    else $error("interval interrupt beside watchdog reset");
  a_rdata_idle: assert property (!$past(rd_en) |-> rdata == 8'h00)
    else $error("read data outside its cycle");
  c_nmi: cover property (nmi_req);
  c_irq: cover property ($rose(interval_overflow_irq[1]));
  c_manual: cover property ($rose(chip_reset) && chip_reset_manual);
  c_por: cover property ($rose(chip_reset) && !chip_reset_manual);
endmodule : wdit_timer_sva
bind wdit_timer wdit_timer_sva #(.RST_CYCLES(RST_CYCLES)) wdit_timer_sva_i (
  .clk(clk), .arst_n(arst_n), .rd_en(rd_en), .rdata(rdata),
  .interval_overflow_irq(interval_overflow_irq), .nmi_req(nmi_req),
  .chip_reset(chip_reset), .chip_reset_manual(chip_reset_manual)
);

// ==== tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic sub_clk_active = 1'b0;
  logic sub_clk_tick = 1'b0;
  logic [7:0] rdata;
  logic [1:0] irq;
  logic nmi_req;
  logic chip_reset;
  logic chip_reset_manual;
  int miscompares = 0;
  int num_checks = 0;
  logic [7:0] d;
  logic s;

  // 100 mhz clock
  always #5 clk = ~clk;

  // short reset pulse keeps the reset scenarios quick
  wdit_timer #(.RST_CYCLES(2)) wdit_timer_i (
    .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .sub_clk_active(sub_clk_active),
    .sub_clk_tick(sub_clk_tick), .interval_overflow_irq(irq), .nmi_req(nmi_req),
    .chip_reset(chip_reset), .chip_reset_manual(chip_reset_manual)
  );

  task end_of_test;
    if (miscompares == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test

  task chk(input logic [7:0] v, input logic [7:0] e);
    num_checks++;
    if (v !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, v, e);
    end
  endtask : chk

  // bus cycles; each starts at the next edge so strobes never get two drivers at once
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task rd(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask : rd

  // bounded wait for one output: 0 irq0, 1 irq1, 2 nmi, 3 chip reset
  task wev(input int w);
    s = 1'b0;
    for (int i = 0; i < 600 && s !== 1'b1; i++) begin
      @(posedge clk);
      #1 s = w == 0 ? irq[0] : w == 1 ? irq[1] : w == 2 ? nmi_req : chip_reset;
    end
  endtask : wev

  task s_regs;
    for (int a = 0; a < 6; a++) begin
      rd(a[3:0]);
      chk(d, 8'h00);
    end
    wr(4'h9, 8'hff);
    rd(4'h9);
    chk(d, 8'h00);
  endtask : s_regs

  // second pass waits for the interrupt again after a clear, but never checks that the clear dropped it
  task s_intv(input logic c);
    logic [3:0] b;
    b = {2'b00, c, 1'b0};
    wr(b, 8'h20);
    for (int k = 0; k < 2; k++) begin
      wr(b + 4'h1, 8'hff);
      wev(int'(c));
      chk(s, 1'b1);
      chk(nmi_req, 1'b0);
      rd(b);
      chk(d[7], 1'b1);
      wr(b, 8'h20);
    end
    wr(b, 8'h00);
  endtask : s_intv

  task s_nmi;
    wr(4'h2, 8'h60);
    wr(4'h3, 8'hff);
    wev(2);
    chk(s, 1'b1);
    chk(irq[1], 1'b0);
    chk(chip_reset, 1'b0);
    rd(4'h4);
    chk(d, 8'h02);
    wr(4'h2, 8'h00);
    wr(4'h4, 8'h00);
  endtask : s_nmi

  task s_rst(input logic c, input logic [7:0] v);
    logic [3:0] b;
    b = {2'b00, c, 1'b0};
    wr(b, v);
    wr(b + 4'h1, 8'hff);
    wev(3);
    chk(s, 1'b1);
    chk(chip_reset_manual, !c);
    chk(nmi_req, 1'b0);
    chk(irq[c], 1'b0);
    rd(4'h4);
    chk(d, c ? 8'h02 : 8'h01);
    wr(b, 8'h00);
    wr(4'h4, 8'h00);
  endtask : s_rst

  // sub-clock stalls on purpose first, then eight periods give four counts at cks 0
  task s_sub;
    @(posedge clk);
    sub_clk_active <= 1'b1;
    wr(4'h0, 8'h20);
    wr(4'h1, 8'h10);
    repeat (20) @(posedge clk);
    rd(4'h1);
    chk(d, 8'h10);
    repeat (8) begin
      @(posedge clk) sub_clk_tick <= 1'b1;
      @(posedge clk) sub_clk_tick <= 1'b0;
    end
    rd(4'h1);
    chk(d, 8'h14);
    @(posedge clk);
    sub_clk_active <= 1'b0;
    repeat (20) @(posedge clk);
    rd(4'h1);
    chk(d == 8'h14, 1'b0);
    wr(4'h0, 8'h00);
  endtask : s_sub

  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    s_regs;
    s_intv(1'b0);
    s_intv(1'b1);
    s_nmi;
    s_rst(1'b0, 8'h78);
    s_rst(1'b1, 8'h78);
    s_sub;
    end_of_test;
  end

  // watchdog: the sequence needs a few thousand cycles at most
  initial begin
    #100000;
    miscompares++;
    end_of_test;
  end
endmodule : tb_top
